/* File: design/dgp_pkg.sv */
// Constants shared by the dual GPIO port block: register indices, byte
// addresses, field positions and values after reset.
// Assumes a 32-bit APB slave port with a 12-bit byte address.
package dgp_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam int          PADDR_W        = 12;
    localparam logic [7:0]  IDX_PORT_A     = 8'h05;
    localparam logic [7:0]  IDX_PORT_B     = 8'h06;
    localparam logic [7:0]  IDX_OPTION     = 8'h81;
    localparam logic [7:0]  IDX_DIR_A      = 8'h85;
    localparam logic [7:0]  IDX_DIR_B      = 8'h86;
    localparam logic [7:0]  IDX_CMP_CTRL   = 8'h9C;
    localparam logic [7:0]  IDX_ANA_CFG    = 8'h9F;
    localparam logic [7:0]  IDX_INT_CTRL   = 8'h0B;
    localparam logic [7:0]  IDX_PERIPH     = 8'h0C;
    localparam logic [11:0] ADDR_PORT_A    = {2'b00, IDX_PORT_A, 2'b00};
    localparam logic [11:0] ADDR_PORT_B    = {2'b00, IDX_PORT_B, 2'b00};
    localparam logic [11:0] ADDR_OPTION    = {2'b00, IDX_OPTION, 2'b00};
    localparam logic [11:0] ADDR_DIR_A     = {2'b00, IDX_DIR_A, 2'b00};
    localparam logic [11:0] ADDR_DIR_B     = {2'b00, IDX_DIR_B, 2'b00};
    localparam logic [11:0] ADDR_CMP_CTRL  = {2'b00, IDX_CMP_CTRL, 2'b00};
    localparam logic [11:0] ADDR_ANA_CFG   = {2'b00, IDX_ANA_CFG, 2'b00};
    localparam logic [11:0] ADDR_INT_CTRL  = {2'b00, IDX_INT_CTRL, 2'b00};
    localparam logic [11:0] ADDR_PERIPH    = {2'b00, IDX_PERIPH, 2'b00};

    // ------------------------------------------------------------------
    // Widths, field positions and values after reset
    // ------------------------------------------------------------------
    localparam int          PA_W           = 6;
    localparam int          PB_W           = 8;
    localparam int          SYNC_STAGES    = 2;
    localparam int          OPT_PULLUP_BIT = 7;
    localparam int          OPT_EDGE_BIT   = 6;
    localparam int          TIMER_PIN_BIT  = 4;
    localparam int          CMP2_PIN_BIT   = 5;
    localparam int          LVP_PIN_BIT    = 3;
    localparam int          EXT_IRQ_BIT    = 0;
    localparam int          CHG_LO_BIT     = 4;
    localparam int          INTC_FLAG_BIT  = 0;
    localparam int          INTC_EN_BIT    = 3;
    localparam int          PER_LVP_BIT    = 0;
    localparam int          PER_CMP1_BIT   = 1;
    localparam int          PER_CMP2_BIT   = 2;
    localparam logic [7:0]  RST_OPTION     = 8'hFF;
    localparam logic [5:0]  RST_DIR_A      = 6'h3F;
    localparam logic [7:0]  RST_DIR_B      = 8'hFF;
    localparam logic [5:0]  RST_CMP_CTRL   = 6'h07;
    localparam logic [7:0]  RST_ANA_CFG    = 8'h00;
    localparam logic [2:0]  RST_PERIPH     = 3'h1;
    localparam logic [7:0]  ANA_CFG_MASK   = 8'hCF;
    localparam logic [2:0]  CFG_DIGITAL    = 3'h3;
    localparam logic [2:0]  CMP_OFF        = 3'h7;
    localparam logic [5:0]  ANALOG_PINS    = 6'h2F;
    localparam logic [5:0]  CMP_INPUT_PINS = 6'h0F;

endpackage : dgp_pkg

/* File: design/dgp_sync.sv */
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no bit is a multi-bit word.
`timescale 1ns/1ns
module dgp_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] dout_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = din;
        dout_nxt = meta_r;
    end

    // Both stages run freely so that the pin view is never stale.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= meta_nxt;
            dout   <= dout_nxt;
        end
    end

endmodule : dgp_sync

/* File: design/dgp_pin_drv.sv */
// Per-bit pin driver: direction, peripheral takeover, open drain, pull-up.
// Assumes all inputs except per_val are registered state of the port block.
`timescale 1ns/1ns
module dgp_pin_drv #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] per_sel,
    input  wire logic [W-1:0] per_oe,
    input  wire logic [W-1:0] per_val,
    input  wire logic [W-1:0] open_drain,
    input  wire logic         pullup_glob,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n,
    output logic      [W-1:0] pullup_en
);

    // ------------------------------------------------------------------
    // One driver per bit
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic val;
            logic drv;
            // A selected peripheral owns the pin, otherwise the port does.
            assign val = per_sel[i] ? per_val[i] : latch[i];
            assign drv = per_sel[i] ? per_oe[i] : ~dir[i];
            // An open-drain bit only ever pulls low.
            assign pin_out[i]   = open_drain[i] ? 1'b0 : val;
            assign pin_oe_n[i]  = ~(drv & ~(open_drain[i] & val));
            // Pull-up only on an input bit while enabled globally.
            assign pullup_en[i] = pullup_glob & dir[i] & ~per_sel[i];
        end
    endgenerate

endmodule : dgp_pin_drv

/* File: design/dgp_port.sv */
// Dual GPIO port block: a 6-bit port with analog, timer and open-drain
// sharing, and an 8-bit port with pull-ups, change flag and external edge.
// Assumes an APB master on core_clk and pin inputs synchronous to it.
//
// Functional notes
// - Enabled peripheral takes over its shared pin.
// - First port six bits, one direction bit each.
// - Direction 1 is input, 0 drives latch.
// - Data read returns pins, write sets latch.
// - Port writes merge sampled pins into latch.
// - Bit 4 feeds timer; output is open-drain.
// - Converter and comparator bits select analog pins.
// - Reset makes analog pins analog, reading zero.
// - Direction still governs analog pins; keep inputs.
// - Unimplemented register bits read as zero.
// - Second port eight bits, same direction encoding.
// - Clearing option bit 7 enables all pull-ups.
// - Output bits never get the pull-up.
// - Pull-ups disabled after power-on reset.
// - Only input bits 7..4 join change detection.
// - Compare inputs with copy; OR sets flag.
// - Mismatch keeps setting flag; access refreshes copy.
// - Change interrupt can wake from sleep.
// - Bit 0 is external edge input; option bit 6.
// - Programming option default on, steals bit 3.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module dgp_port (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  pa_in,
    output logic      [5:0]  pa_out,
    output logic      [5:0]  pa_oe_n,
    input  wire logic [7:0]  pb_in,
    output logic      [7:0]  pb_out,
    output logic      [7:0]  pb_oe_n,
    output logic      [7:0]  pb_pullup_en,
    input  wire logic [1:0]  cmp_result,
    output logic             timer_clk_in,
    output logic      [5:0]  analog_sel,
    output logic             ext_irq_pulse,
    output logic             change_irq_flag,
    output logic             wake_req
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Returns one when the address names a mapped register.
    function automatic logic dgp_mapped(input logic [11:0] a);
        dgp_mapped = (a == dgp_pkg::ADDR_PORT_A)   || (a == dgp_pkg::ADDR_PORT_B)   ||
                     (a == dgp_pkg::ADDR_OPTION)   || (a == dgp_pkg::ADDR_DIR_A)    ||
                     (a == dgp_pkg::ADDR_DIR_B)    || (a == dgp_pkg::ADDR_CMP_CTRL) ||
                     (a == dgp_pkg::ADDR_ANA_CFG)  || (a == dgp_pkg::ADDR_INT_CTRL) ||
                     (a == dgp_pkg::ADDR_PERIPH);
    endfunction : dgp_mapped

    // Returns the set of first-port pins held in analog mode.
    function automatic logic [5:0] dgp_analog_mask(input logic [3:0] cfg,
                                                   input logic [2:0] cmp_mode);
        logic [5:0] m;
        m = '0;
        if (cfg[3:1] != dgp_pkg::CFG_DIGITAL) begin
            m = dgp_pkg::ANALOG_PINS;
        end
        if (cmp_mode != dgp_pkg::CMP_OFF) begin
            m = m | dgp_pkg::CMP_INPUT_PINS;
        end
        dgp_analog_mask = m;
    endfunction : dgp_analog_mask

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [13:0] pin_sync;
    logic [5:0]  pa_sync;
    logic [7:0]  pb_sync;

    // Both ports are sampled through two flops before any use.
    dgp_sync #(
        .W (14)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      ({pb_in, pa_in}),
        .dout     (pin_sync)
    );

    assign pa_sync = pin_sync[5:0];
    assign pb_sync = pin_sync[13:6];

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [5:0]  pa_latch_r;
    logic [5:0]  pa_latch_nxt;
    logic [7:0]  pb_latch_r;
    logic [7:0]  pb_latch_nxt;
    logic [5:0]  pa_dir_r;
    logic [5:0]  pa_dir_nxt;
    logic [7:0]  pb_dir_r;
    logic [7:0]  pb_dir_nxt;
    logic [7:0]  option_r;
    logic [7:0]  option_nxt;
    logic [5:0]  cmp_ctrl_r;
    logic [5:0]  cmp_ctrl_nxt;
    logic [7:0]  ana_cfg_r;
    logic [7:0]  ana_cfg_nxt;
    logic        chg_flag_r;
    logic        chg_flag_nxt;
    logic        chg_en_r;
    logic        chg_en_nxt;
    logic [2:0]  periph_r;
    logic [2:0]  periph_nxt;
    logic [3:0]  chg_copy_r;
    logic [3:0]  chg_copy_nxt;
    logic        ext_prev_r;
    logic        ext_prev_nxt;
    logic        ext_pulse_r;
    logic        ext_pulse_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    // ------------------------------------------------------------------
    // Bus phases and derived pin views
    // ------------------------------------------------------------------
    logic        setup_ph;
    logic        access_ph;
    logic        wr_en;
    logic [7:0]  wmask;
    logic [5:0]  ana_mask;
    logic [5:0]  pa_rd;
    logic [7:0]  pb_rd;
    logic        lvp_on;
    logic [3:0]  mismatch;
    logic        pb_access;

    // Bus phases; the slave never inserts a wait state.
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en     = access_ph & pwrite & dgp_mapped(paddr) & ce;
    assign wmask     = {8{pstrb[0]}};
    assign pb_access = access_ph & ce & (paddr == dgp_pkg::ADDR_PORT_B);

    // Analog pins read as zero while digital pins show their level.
    assign ana_mask = dgp_analog_mask(ana_cfg_r[3:0], cmp_ctrl_r[2:0]);
    assign pa_rd    = pa_sync & ~ana_mask;
    assign lvp_on   = periph_r[dgp_pkg::PER_LVP_BIT];

    // The programming pin is no port bit while its option is on.
    always_comb begin
        pb_rd = pb_sync;
        if (lvp_on) begin
            pb_rd[dgp_pkg::LVP_PIN_BIT] = 1'b0;
        end
    end

    // Eligible input bits differing from the copy taken at last access.
    assign mismatch = (pb_sync[7:4] ^ chg_copy_r) & pb_dir_r[7:4];

    // ------------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------------

    // Port writes merge pin samples with the written lanes; other side effects.
    always_comb begin
        pa_latch_nxt = pa_latch_r;
        pb_latch_nxt = pb_latch_r;
        pa_dir_nxt   = pa_dir_r;
        pb_dir_nxt   = pb_dir_r;
        option_nxt   = option_r;
        cmp_ctrl_nxt = cmp_ctrl_r;
        ana_cfg_nxt  = ana_cfg_r;
        chg_en_nxt   = chg_en_r;
        periph_nxt   = periph_r;
        if (wr_en) begin
            case (paddr)
                dgp_pkg::ADDR_PORT_A: begin
                    pa_latch_nxt = (pa_sync & ~wmask[5:0]) |
                                   (pwdata[5:0] & wmask[5:0]);
                end
                dgp_pkg::ADDR_PORT_B: begin
                    pb_latch_nxt = (pb_sync & ~wmask) | (pwdata[7:0] & wmask);
                end
                dgp_pkg::ADDR_OPTION: begin
                    option_nxt = (option_r & ~wmask) | (pwdata[7:0] & wmask);
                end
                dgp_pkg::ADDR_DIR_A: begin
                    pa_dir_nxt = (pa_dir_r & ~wmask[5:0]) |
                                 (pwdata[5:0] & wmask[5:0]);
                end
                dgp_pkg::ADDR_DIR_B: begin
                    pb_dir_nxt = (pb_dir_r & ~wmask) | (pwdata[7:0] & wmask);
                end
                dgp_pkg::ADDR_CMP_CTRL: begin
                    cmp_ctrl_nxt = (cmp_ctrl_r & ~wmask[5:0]) |
                                   (pwdata[5:0] & wmask[5:0]);
                end
                dgp_pkg::ADDR_ANA_CFG: begin
                    ana_cfg_nxt = (ana_cfg_r & ~wmask) |
                                  (pwdata[7:0] & wmask & dgp_pkg::ANA_CFG_MASK);
                end
                dgp_pkg::ADDR_INT_CTRL: begin
                    if (pstrb[0]) begin
                        chg_en_nxt = pwdata[dgp_pkg::INTC_EN_BIT];
                    end
                end
                dgp_pkg::ADDR_PERIPH: begin
                    if (pstrb[0]) begin
                        periph_nxt = pwdata[2:0];
                    end
                end
                default: begin
                    periph_nxt = periph_r;
                end
            endcase
        end
    end

    // Change flag: hardware set wins over a software clear in one cycle.
    always_comb begin
        chg_flag_nxt = chg_flag_r;
        chg_copy_nxt = chg_copy_r;
        if (wr_en && (paddr == dgp_pkg::ADDR_INT_CTRL) && pstrb[0] &&
            !pwdata[dgp_pkg::INTC_FLAG_BIT]) begin
            chg_flag_nxt = 1'b0;
        end
        if (|mismatch) begin
            chg_flag_nxt = 1'b1;
        end
        if (pb_access) begin
            chg_copy_nxt = pb_sync[7:4];
        end
    end

    // External edge: rising when the select bit is one, else falling.
    always_comb begin
        ext_prev_nxt  = pb_sync[dgp_pkg::EXT_IRQ_BIT];
        ext_pulse_nxt = option_r[dgp_pkg::OPT_EDGE_BIT] ?
                        (pb_sync[dgp_pkg::EXT_IRQ_BIT] & ~ext_prev_r) :
                        (~pb_sync[dgp_pkg::EXT_IRQ_BIT] & ext_prev_r);
    end

    // Read data is captured in the setup cycle, ready in the access cycle.
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup_ph) begin
            prdata_nxt = '0;
            case (paddr)
                dgp_pkg::ADDR_PORT_A:   prdata_nxt[5:0] = pa_rd;
                dgp_pkg::ADDR_PORT_B:   prdata_nxt[7:0] = pb_rd;
                dgp_pkg::ADDR_OPTION:   prdata_nxt[7:0] = option_r;
                dgp_pkg::ADDR_DIR_A:    prdata_nxt[5:0] = pa_dir_r;
                dgp_pkg::ADDR_DIR_B:    prdata_nxt[7:0] = pb_dir_r;
                dgp_pkg::ADDR_CMP_CTRL: prdata_nxt[7:0] = {cmp_result, cmp_ctrl_r};
                dgp_pkg::ADDR_ANA_CFG:  prdata_nxt[7:0] = ana_cfg_r;
                dgp_pkg::ADDR_INT_CTRL: begin
                    prdata_nxt[dgp_pkg::INTC_FLAG_BIT] = chg_flag_r;
                    prdata_nxt[dgp_pkg::INTC_EN_BIT]   = chg_en_r;
                end
                dgp_pkg::ADDR_PERIPH:   prdata_nxt[2:0] = periph_r;
                default:                prdata_nxt = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register file flops
    // ------------------------------------------------------------------

    // All register state holds while the clock enable is low; the pin synchroniser keeps running.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pa_latch_r  <= '0;
            pb_latch_r  <= '0;
            pa_dir_r    <= dgp_pkg::RST_DIR_A;
            pb_dir_r    <= dgp_pkg::RST_DIR_B;
            option_r    <= dgp_pkg::RST_OPTION;
            cmp_ctrl_r  <= dgp_pkg::RST_CMP_CTRL;
            ana_cfg_r   <= dgp_pkg::RST_ANA_CFG;
            chg_en_r    <= 1'b0;
            periph_r    <= dgp_pkg::RST_PERIPH;
            chg_flag_r  <= 1'b0;
            chg_copy_r  <= '0;
            ext_prev_r  <= 1'b0;
            ext_pulse_r <= 1'b0;
            prdata_r    <= '0;
        end else if (ce) begin
            pa_latch_r  <= pa_latch_nxt;
            pb_latch_r  <= pb_latch_nxt;
            pa_dir_r    <= pa_dir_nxt;
            pb_dir_r    <= pb_dir_nxt;
            option_r    <= option_nxt;
            cmp_ctrl_r  <= cmp_ctrl_nxt;
            ana_cfg_r   <= ana_cfg_nxt;
            chg_en_r    <= chg_en_nxt;
            periph_r    <= periph_nxt;
            chg_flag_r  <= chg_flag_nxt;
            chg_copy_r  <= chg_copy_nxt;
            ext_prev_r  <= ext_prev_nxt;
            ext_pulse_r <= ext_pulse_nxt;
            prdata_r    <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    logic [5:0] pa_per_sel;
    logic [5:0] pa_per_val;
    logic [7:0] pb_per_sel;

    // Comparator outputs take bits 4 and 5; the programming option bit 3.
    assign pa_per_sel = {periph_r[dgp_pkg::PER_CMP2_BIT],
                         periph_r[dgp_pkg::PER_CMP1_BIT], 4'h0};
    assign pa_per_val = {cmp_result[1], cmp_result[0], 4'h0};
    assign pb_per_sel = {4'h0, lvp_on, 3'h0};

    // Direction governs analog pins too; software keeps them inputs.
    dgp_pin_drv #(
        .W (6)
    ) u_drv_a (
        .latch       (pa_latch_r),
        .dir         (pa_dir_r),
        .per_sel     (pa_per_sel),
        .per_oe      (pa_per_sel),
        .per_val     (pa_per_val),
        .open_drain  (6'h10),
        .pullup_glob (1'b0),
        .pin_out     (pa_out),
        .pin_oe_n    (pa_oe_n),
        .pullup_en   ()
    );

    // The programming option holds bit 3 released as a plain input.
    dgp_pin_drv #(
        .W (8)
    ) u_drv_b (
        .latch       (pb_latch_r),
        .dir         (pb_dir_r),
        .per_sel     (pb_per_sel),
        .per_oe      (8'h00),
        .per_val     (8'h00),
        .open_drain  (8'h00),
        .pullup_glob (~option_r[dgp_pkg::OPT_PULLUP_BIT]),
        .pin_out     (pb_out),
        .pin_oe_n    (pb_oe_n),
        .pullup_en   (pb_pullup_en)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Bus answers and status views.
    assign prdata          = prdata_r;
    assign pready          = access_ph;
    assign pslverr         = access_ph & ~dgp_mapped(paddr);
    assign timer_clk_in    = pa_sync[dgp_pkg::TIMER_PIN_BIT];
    assign analog_sel      = ana_mask;
    assign ext_irq_pulse   = ext_pulse_r;
    assign change_irq_flag = chg_flag_r;
    assign wake_req        = chg_flag_r & chg_en_r;

endmodule : dgp_port

/* File: testbench/dgp_port_props.sv */
// Concurrent checks on the ports of the dual GPIO port block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module dgp_port_props (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  pa_in,
    input wire logic [5:0]  pa_out,
    input wire logic [5:0]  pa_oe_n,
    input wire logic [7:0]  pb_oe_n,
    input wire logic [7:0]  pb_pullup_en,
    input wire logic        timer_clk_in,
    input wire logic        ext_irq_pulse,
    input wire logic        change_irq_flag,
    input wire logic        wake_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Access phase and read access phase of an APB transfer.
    sequence s_acc; psel && penable; endsequence
    sequence s_rd; s_acc ##0 !pwrite; endsequence
    property p_rdy; s_acc |-> pready; endproperty
    property p_err; pslverr |-> psel && penable; endproperty
    property p_hi; s_rd |-> prdata[31:8] == 24'h00_0000; endproperty
    property p_od; !pa_oe_n[4] |-> !pa_out[4]; endproperty
    property p_pu; (pb_pullup_en & ~pb_oe_n) == 8'h00; endproperty
    property p_wk; wake_req |-> change_irq_flag; endproperty
    property p_sy; $past(nrst, 2) |-> timer_clk_in == $past(pa_in[4], 2); endproperty
    property p_pl; ext_irq_pulse |=> !ext_irq_pulse; endproperty
    property p_fl; change_irq_flag && !(psel && penable && pwrite) |=>
        change_irq_flag; endproperty
    property p_rs; $rose(nrst) |-> pb_pullup_en == 8'h00; endproperty
    a_rdy: assert property (p_rdy) else $error("ready missing");
    a_err: assert property (p_err) else $error("error outside access");
    a_hi: assert property (p_hi) else $error("upper read bits set");
    a_od: assert property (p_od) else $error("open drain drives high");
    a_pu: assert property (p_pu) else $error("pull-up on output");
    a_wk: assert property (p_wk) else $error("wake without flag");
    a_sy: assert property (p_sy) else $error("timer input latency");
    a_pl: assert property (p_pl) else $error("edge pulse too long");
    a_fl: assert property (p_fl) else $error("flag lost");
    a_rs: assert property (p_rs) else $error("pull-up after reset");
endmodule : dgp_port_props
bind dgp_port dgp_port_props u_props (.core_clk, .nrst, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .pa_in, .pa_out, .pa_oe_n, .pb_oe_n, .pb_pullup_en, .timer_clk_in,
    .ext_irq_pulse, .change_irq_flag, .wake_req);

/* File: testbench/dgp_pins.sv */
// Pin model: block drive, external drive, pull-ups, else a toggling float.
// Assumes active-low output enables from the block.
`timescale 1ns/1ns
module dgp_pins (
    input  wire logic       core_clk,
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe_n,
    input  wire logic [5:0] ea_v,
    input  wire logic [5:0] ea_en,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    input  wire logic [7:0] pb_pullup_en,
    input  wire logic [7:0] eb_v,
    input  wire logic [7:0] eb_en,
    output logic      [5:0] pa_in,
    output logic      [7:0] pb_in
);
    logic tog = 1'b0;
    // A floating pin shows a value that changes every cycle.
    always @(posedge core_clk) tog <= ~tog;
    // The block's drive wins, then the outside drive, then pull-up or float.
    assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & ((ea_en & ea_v) | (~ea_en & {6{tog}})));
    assign pb_in = (~pb_oe_n & pb_out) | (pb_oe_n & ((eb_en & eb_v) | (~eb_en
                   & (pb_pullup_en | {8{tog}}))));
endmodule : dgp_pins

/* File: testbench/tb_dual_gpio_port_with_change_irq.sv */
// Self-checking bench for the dual GPIO port block over APB.
// Assumes zero-wait APB answers and two-flop pin synchronisers.
`timescale 1ns/1ns
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %0t %s", $time, m); end end
module tb_dual_gpio_port_with_change_irq;
    logic core_clk = 0, nrst = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic [3:0] pstrb = 0;
    logic [5:0] pa_in, pa_out, pa_oe_n, analog_sel, ea_v = 6'h3F, ea_en = 6'h3F;
    logic [7:0] pb_in, pb_out, pb_oe_n, pb_pullup_en, eb_v = 0, eb_en = 8'hFF;
    logic [1:0] cmp_result = 0;
    logic timer_clk_in, ext_irq_pulse, change_irq_flag, wake_req, er, hit;
    int n_errors = 0, checks = 0;
    dgp_port dut (.core_clk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .pa_in, .pa_out, .pa_oe_n, .pb_in, .pb_out, .pb_oe_n,
        .pb_pullup_en, .cmp_result, .timer_clk_in, .analog_sel, .ext_irq_pulse,
        .change_irq_flag, .wake_req);
    dgp_pins u_pins (.core_clk, .pa_out, .pa_oe_n, .ea_v, .ea_en, .pb_out, .pb_oe_n,
        .pb_pullup_en, .eb_v, .eb_en, .pa_in, .pb_in);
    initial forever #50 core_clk = ~core_clk;
    task report_and_stop;
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // One APB transfer; read data and error are taken at the ready edge.
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
        int i;
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, 24'h00_0000, d, 3'h0, s};
        @(posedge core_clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        {rv, er} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        if (i == 20) begin `CHK(1'b0, 1'b1, "hang") report_and_stop; end
        @(negedge core_clk);
    endtask : apb
    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(0, a, 8'h00, 1);
        `CHK(rv, {24'h00_0000, e}, "read")
    endtask : rd
    // Waits a bounded time for the edge pulse (0) or the change flag (1).
    task wait_hi(input int s);
        hit = 0;
        repeat (9) begin
            @(negedge core_clk);
            if ((s ? change_irq_flag : ext_irq_pulse) === 1'b1) hit = 1;
        end
        `CHK(hit, 1'b1, "event missing")
    endtask : wait_hi
    task t_reset;
        rd(12'h204, 8'hFF); rd(12'h214, 8'h3F); rd(12'h218, 8'hFF);
        rd(12'h270, 8'h07); rd(12'h27C, 8'h00); rd(12'h014, 8'h10);
        rd(12'h3FC, 8'h00); `CHK(er, 1'b1, "unmapped")
        `CHK({pb_pullup_en, analog_sel}, 14'h002F, "reset pins")
    endtask : t_reset
    task t_port_a;
        apb(1, 12'h27C, 8'h06, 1); `CHK(analog_sel, 6'h00, "digital")
        ea_en <= 0; apb(1, 12'h214, 8'h00, 1); apb(1, 12'h014, 8'h2A, 1);
        `CHK({pa_oe_n, pa_out}, 12'h02A, "drive")
        repeat (3) @(posedge core_clk); rd(12'h014, 8'h2A);
        apb(1, 12'h014, 8'h3F, 1); `CHK(pa_oe_n, 6'h10, "open drain")
        apb(1, 12'h214, 8'h3F, 1); {ea_en, ea_v} <= 12'hFD5; repeat (3) @(posedge core_clk);
        apb(1, 12'h014, 8'h00, 0); apb(1, 12'h214, 8'h00, 1);
        `CHK({pa_oe_n, pa_out & 6'h2F}, 12'h405, "merge")
    endtask : t_port_a
    task t_port_b;
        apb(1, 12'h204, 8'h7F, 1); apb(1, 12'h218, 8'hF0, 1);
        `CHK(pb_pullup_en & 8'hF7, 8'hF0, "pull-ups")
        apb(1, 12'h218, 8'h00, 1); `CHK(pb_oe_n, 8'h08, "prog pin")
        ce <= 0; apb(1, 12'h030, 8'h00, 1); ce <= 1; `CHK(pb_oe_n, 8'h08, "frozen")
        apb(1, 12'h030, 8'h00, 1); `CHK(pb_oe_n, 8'h00, "prog off")
        apb(1, 12'h018, 8'h05, 1); `CHK(pb_out, 8'h05, "port b drive")
    endtask : t_port_b
    task t_change;
        apb(1, 12'h218, 8'hF8, 1); apb(1, 12'h02C, 8'h08, 1); repeat (3) @(posedge core_clk);
        rd(12'h018, 8'h05); apb(1, 12'h02C, 8'h08, 1);
        eb_v <= 8'h08; repeat (6) @(posedge core_clk);
        `CHK(change_irq_flag, 1'b0, "low bit change")
        eb_v <= 8'h28; wait_hi(1); `CHK(wake_req, 1'b1, "wake")
        apb(1, 12'h02C, 8'h08, 1); `CHK(change_irq_flag, 1'b1, "kept")
        rd(12'h018, 8'h2D); apb(1, 12'h02C, 8'h08, 1);
        `CHK(change_irq_flag, 1'b0, "cleared")
    endtask : t_change
    task t_edge;
        apb(1, 12'h218, 8'hFF, 1); apb(1, 12'h204, 8'h40, 1);
        eb_v <= 8'h29; wait_hi(0);
        apb(1, 12'h204, 8'h00, 1); eb_v <= 8'h28; wait_hi(0);
    endtask : t_edge
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1;
        t_reset; t_port_a; t_port_b; t_change; t_edge;
        report_and_stop;
    end
endmodule : tb_dual_gpio_port_with_change_irq
